// [shared/level_assign_pkg.sv]
// constants for the interrupt level assignment registers
package level_assign_pkg;
  localparam logic [15:0] SERIAL_ADDR     = 16'hf026;
  localparam logic [15:0] OSC_ADDR        = 16'hf028;
  localparam logic [15:0] CONV_ADDR       = 16'hf02a;
  localparam logic [15:0] TIMER_ADDR      = 16'hf02c;
  localparam logic [15:0] REG_RESET       = 16'h0000;
  // writable bits per register; all other bits read zero
  localparam logic [15:0] SERIAL_MASK     = 16'h3fff;
  localparam logic [15:0] OSC_MASK        = 16'hfc00;
  localparam logic [15:0] CONV_MASK       = 16'h0f0f;
  localparam logic [15:0] TIMER_MASK      = 16'hffff;
  localparam int          FIFO_UART_POS   = 12;
  localparam int          SLOW_OSC_POS    = 10;
  localparam int          SUPERVISOR_POS  = 12;
  localparam int          MELODY_POS      = 14;
  localparam int          SAR_ADC_POS     = 0;
  localparam int          RC_ADC_POS      = 2;
  localparam int          COMP_A_POS      = 8;
  localparam int          COMP_B_POS      = 10;
  localparam int          NUM_SOURCES     = 16;
  localparam int          SRC_SERIAL_BASE = 0;
  localparam int          SRC_OSC         = 1;
  localparam int          SRC_SUPERVISOR  = 2;
  localparam int          SRC_MELODY      = 3;
  localparam int          SRC_SAR_ADC     = 4;
  localparam int          SRC_RC_ADC      = 5;
  localparam int          SRC_COMP_A      = 6;
  localparam int          SRC_COMP_B      = 7;
  localparam int          SRC_TIMER_BASE  = 8;
endpackage

// [core/interrupt_level_assign.sv]
// per-source interrupt level registers and level-based request selection
`timescale 1ns/10ps
`default_nettype none
module interrupt_level_assign #(
  parameter int ADDR_WIDTH = 16
) (
  input  wire logic                  core_clk_in,
  input  wire logic                  reset_in,
  input  wire logic [ADDR_WIDTH-1:0] addr_in,
  input  wire logic [15:0]           wdata_in,
  input  wire logic [1:0]            byte_en_in,
  input  wire logic                  write_in,
  input  wire logic                  read_in,
  input  wire logic                  level_control_enable_in,
  input  wire logic [15:0]           irq_pending_in,
  input  wire logic [15:0]           irq_enable_in,
  output logic [15:0]                rdata_out,
  output logic                       req_valid_out,
  output logic [3:0]                 req_source_out,
  output logic [1:0]                 req_level_out,
  output logic [31:0]                source_levels_out
);

  // the decoder compares sixteen address bits, a narrower bus cannot reach the registers
  if (ADDR_WIDTH < 16)
  begin : g_bad_width
    $error("ADDR_WIDTH must be at least 16");
  end

  typedef struct packed {
    logic [15:0] serial;
    logic [15:0] osc;
    logic [15:0] conv;
    logic [15:0] timer;
    logic [15:0] rdata;
    logic        valid;
    logic [3:0]  source;
    logic [1:0]  level;
  } state_type;

  state_type   state_reg;
  state_type   state_next;
  logic [15:0] lane_mask;
  logic [15:0] addr16;
  logic [31:0] levels;
  logic        found;
  logic [3:0]  best_src;
  logic [1:0]  best_lvl;

  assign addr16 = addr_in[15:0];
  // byte enables pick the halves written, a halfword uses both
  assign lane_mask = {{8{byte_en_in[1]}}, {8{byte_en_in[0]}}};

  // per-source levels in a fixed source order
  always_comb
  begin
    levels = '0;
    levels[1:0]   = state_reg.serial[level_assign_pkg::FIFO_UART_POS +: 2];
    levels[3:2]   = state_reg.osc[level_assign_pkg::SLOW_OSC_POS +: 2];
    levels[5:4]   = state_reg.osc[level_assign_pkg::SUPERVISOR_POS +: 2];
    levels[7:6]   = state_reg.osc[level_assign_pkg::MELODY_POS +: 2];
    levels[9:8]   = state_reg.conv[level_assign_pkg::SAR_ADC_POS +: 2];
    levels[11:10] = state_reg.conv[level_assign_pkg::RC_ADC_POS +: 2];
    levels[13:12] = state_reg.conv[level_assign_pkg::COMP_A_POS +: 2];
    levels[15:14] = state_reg.conv[level_assign_pkg::COMP_B_POS +: 2];
    levels[31:16] = state_reg.timer;
  end

  // highest level wins; ties go to the lowest source index
  always_comb
  begin
    found    = 1'b0;
    best_src = 4'h0;
    best_lvl = 2'h0;
    for (int i = 0; i < 16; i++)
    begin
      if (irq_pending_in[i] && irq_enable_in[i])
      begin
        if (!found || levels[2*i +: 2] > best_lvl)
        begin
          found    = 1'b1;
          best_src = 4'(i);
          best_lvl = levels[2*i +: 2];
        end
      end
    end
  end

  // register writes, read data and request pipeline
  always_comb
  begin
    state_next       = state_reg;
    state_next.rdata = 16'h0000;
    if (write_in && level_control_enable_in)
    begin
      case (addr16)
        level_assign_pkg::SERIAL_ADDR:
          state_next.serial = (state_reg.serial & ~(lane_mask & level_assign_pkg::SERIAL_MASK))
                            | (wdata_in & lane_mask & level_assign_pkg::SERIAL_MASK);
        level_assign_pkg::OSC_ADDR:
          state_next.osc = (state_reg.osc & ~(lane_mask & level_assign_pkg::OSC_MASK))
                         | (wdata_in & lane_mask & level_assign_pkg::OSC_MASK);
        level_assign_pkg::CONV_ADDR:
          state_next.conv = (state_reg.conv & ~(lane_mask & level_assign_pkg::CONV_MASK))
                          | (wdata_in & lane_mask & level_assign_pkg::CONV_MASK);
        level_assign_pkg::TIMER_ADDR:
          state_next.timer = (state_reg.timer & ~lane_mask)
                           | (wdata_in & lane_mask);
        default:
          state_next.timer = state_reg.timer; // unmapped writes are dropped
      endcase
    end
    if (read_in)
    begin
      case (addr16)
        level_assign_pkg::SERIAL_ADDR: state_next.rdata = state_reg.serial;
        level_assign_pkg::OSC_ADDR:    state_next.rdata = state_reg.osc;
        level_assign_pkg::CONV_ADDR:   state_next.rdata = state_reg.conv;
        level_assign_pkg::TIMER_ADDR:  state_next.rdata = state_reg.timer;
        default:                       state_next.rdata = 16'h0000;
      endcase
    end
    state_next.valid  = found;
    state_next.source = best_src;
    state_next.level  = best_lvl;
  end

  // synchronous reset puts every level back to level 1
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      state_reg        <= '0;
      state_reg.serial <= level_assign_pkg::REG_RESET;
      state_reg.osc    <= level_assign_pkg::REG_RESET;
      state_reg.conv   <= level_assign_pkg::REG_RESET;
      state_reg.timer  <= level_assign_pkg::REG_RESET;
    end
    else
      state_reg <= state_next;
  end

  assign rdata_out         = state_reg.rdata;
  assign req_valid_out     = state_reg.valid;
  assign req_source_out    = state_reg.source;
  assign req_level_out     = state_reg.level;
  assign source_levels_out = levels;

  // enabled write to one register with the given byte lanes
  sequence enabled_write_s(logic [15:0] a, logic [1:0] b);
    write_in && level_control_enable_in && addr16 == a && byte_en_in == b;
  endsequence

  // lone read strobe aimed at one register
  sequence read_s(logic [15:0] a);
    read_in && !write_in && addr16 == a;
  endsequence

  // address hits none of the four level registers
  logic addr_unmapped;
  assign addr_unmapped = !(addr16 inside {level_assign_pkg::SERIAL_ADDR,
                                          level_assign_pkg::OSC_ADDR,
                                          level_assign_pkg::CONV_ADDR,
                                          level_assign_pkg::TIMER_ADDR});

  // a write with the enable clear leaves the register untouched
  blocked_write_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    write_in && !level_control_enable_in |=> $stable(state_reg.timer) && $stable(state_reg.osc))
    else $error("level register changed while level control disabled");

  // the other two registers are just as deaf while the enable is clear
  blocked_other_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    write_in && !level_control_enable_in |=> $stable(state_reg.serial) && $stable(state_reg.conv))
    else $error("level register changed while level control disabled");

  // without an enabled write no level ever moves
  level_hold_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !(write_in && level_control_enable_in) |=> $stable(state_reg.serial) && $stable(state_reg.osc)
    && $stable(state_reg.conv) && $stable(state_reg.timer))
    else $error("level register changed without an enabled write");

  // a write to a hole in the map is dropped
  unmapped_write_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    write_in && addr_unmapped |=> $stable(state_reg.serial) && $stable(state_reg.osc)
    && $stable(state_reg.conv) && $stable(state_reg.timer))
    else $error("unmapped write changed a level register");

  // reserved bits never become set
  reserved_zero_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ((state_reg.osc & ~level_assign_pkg::OSC_MASK) == 16'h0000)
    && ((state_reg.conv & ~level_assign_pkg::CONV_MASK) == 16'h0000)
    && ((state_reg.serial & ~level_assign_pkg::SERIAL_MASK) == 16'h0000))
    else $error("reserved level bit set");

  // halfword write to the serial register keeps only its field bits
  serial_write_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    enabled_write_s(level_assign_pkg::SERIAL_ADDR, 2'b11)
    |=> state_reg.serial == ($past(wdata_in) & level_assign_pkg::SERIAL_MASK))
    else $error("serial level register not written");

  // halfword write to the oscillator register lands in its three fields
  osc_write_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    enabled_write_s(level_assign_pkg::OSC_ADDR, 2'b11)
    |=> state_reg.osc == ($past(wdata_in) & level_assign_pkg::OSC_MASK))
    else $error("oscillator level register not written");

  // halfword write to the converter register lands in its four fields
  conv_write_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    enabled_write_s(level_assign_pkg::CONV_ADDR, 2'b11)
    |=> state_reg.conv == ($past(wdata_in) & level_assign_pkg::CONV_MASK))
    else $error("converter level register not written");

  // an enabled timer write lands its low byte next cycle
  timer_write_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    write_in && level_control_enable_in && byte_en_in[0]
    && addr16 == level_assign_pkg::TIMER_ADDR
    |=> state_reg.timer[7:0] == $past(wdata_in[7:0]))
    else $error("timer level low byte not written");

  // every timer bit is a field bit, a halfword write lands whole
  timer_halfword_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    enabled_write_s(level_assign_pkg::TIMER_ADDR, 2'b11)
    |=> state_reg.timer == $past(wdata_in))
    else $error("timer level register not written");

  // a low-byte-only write keeps the high byte
  byte_lane_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    write_in && byte_en_in == 2'b01 |=> $stable(state_reg.timer[15:8]))
    else $error("high byte changed on low byte write");

  // a high-byte-only timer write keeps the low byte
  high_byte_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    enabled_write_s(level_assign_pkg::TIMER_ADDR, 2'b10)
    |=> $stable(state_reg.timer[7:0]) && state_reg.timer[15:8] == $past(wdata_in[15:8]))
    else $error("timer high byte write wrong");

  // low byte write to the converter register leaves the comparator fields
  conv_low_byte_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    enabled_write_s(level_assign_pkg::CONV_ADDR, 2'b01)
    |=> $stable(state_reg.conv[15:8])
    && state_reg.conv[7:0] == ($past(wdata_in[7:0]) & level_assign_pkg::CONV_MASK[7:0]))
    else $error("converter low byte write wrong");

  // high byte write to the oscillator register leaves the low byte
  osc_high_byte_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    enabled_write_s(level_assign_pkg::OSC_ADDR, 2'b10)
    |=> $stable(state_reg.osc[7:0])
    && state_reg.osc[15:8] == ($past(wdata_in[15:8]) & level_assign_pkg::OSC_MASK[15:8]))
    else $error("oscillator high byte write wrong");

  // low byte write to the serial register leaves the high byte
  serial_low_byte_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    enabled_write_s(level_assign_pkg::SERIAL_ADDR, 2'b01)
    |=> $stable(state_reg.serial[15:8])
    && state_reg.serial[7:0] == ($past(wdata_in[7:0]) & level_assign_pkg::SERIAL_MASK[7:0]))
    else $error("serial low byte write wrong");

  // high byte write to the serial register carries the fifo uart field
  serial_high_byte_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    enabled_write_s(level_assign_pkg::SERIAL_ADDR, 2'b10)
    |=> $stable(state_reg.serial[7:0])
    && state_reg.serial[15:8] == ($past(wdata_in[15:8]) & level_assign_pkg::SERIAL_MASK[15:8]))
    else $error("serial high byte write wrong");

  // read data matches the register in the following cycle
  read_data_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    read_in && !write_in && addr16 == level_assign_pkg::CONV_ADDR
    |=> rdata_out == $past(state_reg.conv))
    else $error("read data wrong for converter register");

  // serial register read back
  read_serial_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    read_s(level_assign_pkg::SERIAL_ADDR) |=> rdata_out == $past(state_reg.serial))
    else $error("read data wrong for serial register");

  // oscillator register read back
  read_osc_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    read_s(level_assign_pkg::OSC_ADDR) |=> rdata_out == $past(state_reg.osc))
    else $error("read data wrong for oscillator register");

  // timer register read back
  read_timer_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    read_s(level_assign_pkg::TIMER_ADDR) |=> rdata_out == $past(state_reg.timer))
    else $error("read data wrong for timer register");

  // holes in the map read as zero
  unmapped_read_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    read_in && addr_unmapped |=> rdata_out == 16'h0000)
    else $error("unmapped read returned data");

  // read data stands one cycle only, so a shared bus can or it with others
  read_idle_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !read_in |=> rdata_out == 16'h0000)
    else $error("read data left standing");

  // the chosen request is enabled and pending
  req_enabled_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    req_valid_out |-> (($past(irq_pending_in & irq_enable_in) >> req_source_out) & 16'h0001)
      == 16'h0001)
    else $error("request from a source not enabled");

  // nothing enabled and pending gives no request
  idle_request_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (irq_pending_in & irq_enable_in) == 16'h0000 |=> !req_valid_out)
    else $error("request raised with no enabled source");

  for (genvar g = 0; g < level_assign_pkg::NUM_SOURCES; g++)
  begin : g_rank
    // no enabled pending source outranks the winner, ties go to the lower index
    rank_order_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      irq_pending_in[g] && irq_enable_in[g]
      |=> req_valid_out && (req_level_out > $past(levels[2*g +: 2])
        || (req_level_out == $past(levels[2*g +: 2]) && req_source_out <= 4'(g))))
      else $error("lower level request chosen");
  end

  // after reset every level reads as level 1
  reset_level_a: assert property (@(posedge core_clk_in)
    reset_in |=> source_levels_out == 32'h00000000)
    else $error("levels not reset to level 1");

  // reset also clears the request and the read data
  reset_outputs_a: assert property (@(posedge core_clk_in)
    reset_in |=> !req_valid_out && rdata_out == 16'h0000)
    else $error("outputs not cleared by reset");

endmodule
`default_nettype wire

// [dv/irq_source_model.sv]
// interrupt sources and cpu enable mask facing the level block
`timescale 1ns/10ps
`default_nettype none
module irq_source_model (
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic [15:0] raise_in,
  input  wire logic [15:0] enable_set_in,
  input  wire logic        mask_all_in,
  input  wire logic        ack_in,
  input  wire logic [3:0]  ack_source_in,
  output var  logic [15:0] pending_out,
  output logic      [15:0] enable_out
);
  // a pending flag sticks until its source is served, so low levels can starve
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      pending_out <= 16'h0000;
    else
      pending_out <= (pending_out & ~({15'h0000, ack_in} << ack_source_in)) | raise_in;
  end
  // cpu drops every enable while level registers are rewritten
  assign enable_out = mask_all_in ? 16'h0000 : enable_set_in;
endmodule
`default_nettype wire

// [dv/test_interrupt_level_assign.sv]
// self-checking bench for the interrupt level registers and selection
`timescale 1ns/10ps
`default_nettype none
module test_interrupt_level_assign;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] raise = 16'h0000;
  logic [15:0] ensel = 16'h0000;
  logic [1:0]  be = 2'b00;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        lce = 1'b0;
  logic        mask = 1'b0;
  logic        live = 1'b0;
  logic        rd_q = 1'b0;
  logic [15:0] rdata, pend, en;
  logic [15:0] shadow [5];
  logic        rv;
  logic [3:0]  rs;
  logic [1:0]  rl;
  logic [31:0] lv;
  logic [6:0]  exp_w = 7'h00;
  integer      seed = 32'h5f2f43e3;
  int          n_errors = 0;
  int          n_tests = 0;
  int          n_cycles = 0;

  always #2 clk = ~clk;

  interrupt_level_assign i_interrupt_level_assign (.core_clk_in(clk), .reset_in(rst),
    .addr_in(addr), .wdata_in(wdata), .byte_en_in(be), .write_in(wr_s), .read_in(rd_s),
    .level_control_enable_in(lce), .irq_pending_in(pend), .irq_enable_in(en),
    .rdata_out(rdata), .req_valid_out(rv), .req_source_out(rs), .req_level_out(rl),
    .source_levels_out(lv));
  irq_source_model i_irq_source_model (.core_clk_in(clk), .reset_in(rst), .raise_in(raise),
    .enable_set_in(ensel), .mask_all_in(mask), .ack_in(rv), .ack_source_in(rs),
    .pending_out(pend), .enable_out(en));

  task automatic report_and_stop();
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] mask_of(input int r);
    case (r)
      0: return level_assign_pkg::SERIAL_MASK;
      1: return level_assign_pkg::OSC_MASK;
      2: return level_assign_pkg::CONV_MASK;
      3: return level_assign_pkg::TIMER_MASK;
      default: return 16'h0000;
    endcase
  endfunction

  // source i level sits at bits 2i+1:2i, timers fill the upper half
  function automatic logic [31:0] exp_levels();
    return {shadow[3], shadow[2][11:8], shadow[2][3:0], shadow[1][15:10], shadow[0][13:12]};
  endfunction

  // scanning down with >= leaves the lowest index on a tie
  function automatic logic [6:0] exp_win(input logic [15:0] act, input logic [31:0] lvl);
    logic [6:0] w;
    w = 7'h00;
    for (int i = 15; i >= 0; i--)
      if (act[i] && (!w[6] || lvl[2*i +: 2] >= w[1:0]))
        w = {1'b1, 4'(i), lvl[2*i +: 2]};
    return w;
  endfunction

  // register index 4 lands on an unmapped address
  task automatic wr(input int r, input logic [15:0] d, input logic [1:0] b, input logic e);
    logic [15:0] m;
    @(posedge clk);
    addr <= level_assign_pkg::SERIAL_ADDR + 16'(2 * r);
    wdata <= d;
    be <= b;
    lce <= e;
    mask <= 1'b1;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    mask <= 1'b0;
    m = e ? mask_of(r) & {{8{b[1]}}, {8{b[0]}}} : 16'h0000;
    shadow[r] = (shadow[r] & ~m) | (d & m);
  endtask

  task automatic rd(input int r);
    @(posedge clk);
    addr <= level_assign_pkg::SERIAL_ADDR + 16'(2 * r);
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    cmp({16'h0000, rdata}, {16'h0000, shadow[r]});
    cmp(lv, exp_levels());
  endtask

  // winner checked every cycle against the inputs seen one cycle earlier
  always @(negedge clk)
  begin
    if (!rst && live)
      cmp({25'h0, rv, exp_w[6] ? {rs, rl} : 6'h00}, {25'h0, exp_w});
    // read data must read zero in every cycle that follows no read strobe
    if (!rst && live && !rd_q)
      cmp({16'h0000, rdata}, 32'h00000000);
    live = !rst;
    rd_q = rd_s;
    exp_w = exp_win(pend & en, exp_levels());
    n_cycles++;
    if (n_cycles > 6000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  // sparse random requests, enables reshuffled every sixteen cycles
  always @(posedge clk)
  begin
    raise <= 16'($random(seed)) & 16'($random(seed)) & 16'($random(seed));
    if (n_cycles % 16 == 0)
      ensel <= 16'($random(seed));
  end

  initial
  begin
    for (int r = 0; r < 5; r++)
      shadow[r] = 16'h0000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int r = 0; r < 5; r++)
      rd(r);
    wr(3, 16'hffff, 2'b11, 1'b0);
    rd(3);
    for (int i = 0; i < 400; i++)
    begin
      wr(i % 5, 16'($random(seed)), 2'((i % 3) + 1), (i % 4) != 3);
      rd((i * 7) % 5);
    end
    // a second reset in mid-run brings every level back to level 1
    @(posedge clk);
    rst <= 1'b1;
    for (int r = 0; r < 5; r++)
      shadow[r] = 16'h0000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int r = 0; r < 5; r++)
      rd(r);
    report_and_stop();
  end
endmodule
`default_nettype wire
